// File: core/eip_params.svh
// Register map, field positions and reset values of the edge/port block
`ifndef EIP_PARAMS_SVH
`define EIP_PARAMS_SVH

// Bank codes in address bits 6:4, port index in bits 3:0
`define EIP_BANK_RISE_EN   3'h0
`define EIP_BANK_FALL_EN   3'h1
`define EIP_BANK_RISE_ST   3'h2
`define EIP_BANK_FALL_ST   3'h3
`define EIP_BANK_DATA      3'h4
`define EIP_ADDR_CTL       7'h50
`define EIP_ADDR_SIMIO     7'h51

// Global control fields; bit 7 is unused and reads zero
`define EIP_CTL_IN_LSB     0
`define EIP_CTL_OUT_LSB    3
`define EIP_CTL_GRP_WIDTH  3
`define EIP_CTL_ACK_BIT    6
`define EIP_CTL_MASK       8'h7f
`define EIP_CTL_RESET      8'h00

// Simultaneous I/O trigger fields
`define EIP_SIM_SAMPLE_POS 0
`define EIP_SIM_COMMIT_POS 4

// Misc
`define EIP_BYTE_RESET     8'h00
`define EIP_REAR_FIRST     4'h8

`endif

// File: core/eip_pkg.sv
// Types shared by the edge interrupt and port data block
package eip_pkg;

  // One register request, valid for one cycle
  typedef struct packed {
    logic       valid;
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } eip_req_type;

  // Acknowledge method for the edge status bits
  typedef enum logic {
    EIP_ACK_WRITE = 1'b0,
    EIP_ACK_READ  = 1'b1
  } eip_ack_type;

  typedef logic [15:0][7:0] eip_bytes_type;

endpackage

// File: core/eip_edge_port.sv
// Edge interrupt status/enable and port data registers for 16 x 8 lines
`timescale 1ns/10ps
`include "eip_params.svh"

module eip_edge_port #(
  parameter bit GND_VARIANT = 1'b0
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire eip_pkg::eip_req_type reg_req,
  output logic [7:0]                reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic [15:0]          port_dir_out,
  input  wire logic [127:0]         line_in,
  output logic [127:0]              line_out,
  output logic [127:0]              line_oe_n,
  output logic                      irq
);
  import eip_pkg::*;
  // Port 15 lines are ground on the reduced variant
  localparam logic [127:0] LIVE_MASK = GND_VARIANT ? {8'h00, {120{1'b1}}} : {128{1'b1}};

  logic [127:0]  s1_q;
  logic [127:0]  s2_q;
  logic [127:0]  s3_q;
  logic [127:0]  lvl_q;
  logic [127:0]  prev_q;
  logic [127:0]  rise_ev;
  logic [127:0]  fall_ev;
  eip_bytes_type rise_en_q;
  eip_bytes_type fall_en_q;
  eip_bytes_type rise_st_q;
  eip_bytes_type fall_st_q;
  eip_bytes_type rise_clr;
  eip_bytes_type fall_clr;
  eip_bytes_type out_q;
  eip_bytes_type drv_q;
  eip_bytes_type snap_q;
  eip_bytes_type src;
  eip_bytes_type view;
  logic [7:0]    ctl_q;
  logic [7:0]    rdata_d;
  logic [2:0]    in_en;
  logic [2:0]    out_en;
  logic [2:0]    sample;
  logic [2:0]    commit;
  logic          wr;
  logic          rd;
  logic [2:0]    bank;
  logic [3:0]    idx;
  eip_ack_type   ack_mode;

  // Group membership of a port for a front/rear/all selector
  function automatic logic grp_hit(input logic [3:0] p, input logic [2:0] sel);
    return sel[2] | ((p < `EIP_REAR_FIRST) ? sel[0] : sel[1]);
  endfunction
  // Clear vector for one status bank under the selected acknowledge method
  function automatic eip_bytes_type clr_vec(input eip_req_type r, input eip_ack_type m,
                                            input logic [2:0] sel);
    eip_bytes_type v;
    v = '0;
    if (r.valid && r.addr[6:4] == sel)
    begin
      if (r.we && m == EIP_ACK_WRITE)
        v[r.addr[3:0]] = r.wdata;
      else if (!r.we && m == EIP_ACK_READ)
        v[r.addr[3:0]] = 8'hff;
    end
    return v;
  endfunction

  // Request decode
  assign wr       = reg_req.valid & reg_req.we;
  assign rd       = reg_req.valid & ~reg_req.we;
  assign bank     = reg_req.addr[6:4];
  assign idx      = reg_req.addr[3:0];
  assign ack_mode = eip_ack_type'(ctl_q[`EIP_CTL_ACK_BIT]);
  assign in_en    = ctl_q[`EIP_CTL_IN_LSB +: `EIP_CTL_GRP_WIDTH];
  assign out_en   = ctl_q[`EIP_CTL_OUT_LSB +: `EIP_CTL_GRP_WIDTH];
  // Triggers only act for groups whose simultaneous mode is enabled
  always_comb
  begin
    sample = 3'h0;
    commit = 3'h0;
    if (wr && reg_req.addr == `EIP_ADDR_SIMIO)
    begin
      sample = reg_req.wdata[`EIP_SIM_SAMPLE_POS +: 3] & in_en;
      commit = reg_req.wdata[`EIP_SIM_COMMIT_POS +: 3] & out_en;
    end
  end

  // Three-stage sync; a level change counts once stages two and three agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      prev_q <= '0;
    end
    else
    begin
      s1_q   <= line_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      prev_q <= lvl_q;
    end
  end

  // Edge events, masked to connected lines
  assign rise_ev = lvl_q & ~prev_q & LIVE_MASK;
  assign fall_ev = ~lvl_q & prev_q & LIVE_MASK;
  // Arm registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rise_en_q <= '0;
      fall_en_q <= '0;
    end
    else if (wr && bank == `EIP_BANK_RISE_EN)
      rise_en_q[idx] <= reg_req.wdata;
    else if (wr && bank == `EIP_BANK_FALL_EN)
      fall_en_q[idx] <= reg_req.wdata;
  end

  // Acknowledge method picks the clear source for both status banks
  assign rise_clr = clr_vec(reg_req, ack_mode, `EIP_BANK_RISE_ST);
  assign fall_clr = clr_vec(reg_req, ack_mode, `EIP_BANK_FALL_ST);
  // Pending bits; a new event in the clearing cycle survives
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rise_st_q <= '0;
      fall_st_q <= '0;
    end
    else
    begin
      rise_st_q <= (rise_st_q & ~rise_clr) | (rise_ev & rise_en_q);
      fall_st_q <= (fall_st_q & ~fall_clr) | (fall_ev & fall_en_q);
    end
  end
  // Global control register; the unused top bit is masked so it reads zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctl_q <= `EIP_CTL_RESET;
    else if (wr && reg_req.addr == `EIP_ADDR_CTL)
      ctl_q <= reg_req.wdata & `EIP_CTL_MASK;
  end
  // Written output values, buffer side of simultaneous output
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      out_q <= '0;
    else if (wr && bank == `EIP_BANK_DATA)
      out_q[idx] <= reg_req.wdata;
  end

  // Driven values: direct in normal mode, on commit in simultaneous mode
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      drv_q <= '0;
    else
    begin
      for (int p = 0; p < 16; p++)
      begin
        if (grp_hit(4'(p), out_en))
        begin
          if (grp_hit(4'(p), commit))
            drv_q[p] <= out_q[p];
        end
        else if (wr && bank == `EIP_BANK_DATA && idx == 4'(p))
          drv_q[p] <= reg_req.wdata;
        else
          drv_q[p] <= out_q[p];
      end
    end
  end

  // Readback source: pins for inputs, driven values for outputs
  always_comb
  begin
    for (int p = 0; p < 16; p++)
    begin
      src[p]  = port_dir_out[p] ? drv_q[p] : lvl_q[8*p +: 8];
      view[p] = grp_hit(4'(p), in_en) ? snap_q[p] : src[p];
    end
  end

  // Snapshot; every trigger takes fresh values
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      snap_q <= '0;
    else
    begin
      for (int p = 0; p < 16; p++)
      begin
        if (grp_hit(4'(p), sample))
          snap_q[p] <= src[p];
      end
    end
  end

  // Read mux; unmapped addresses and the trigger register read zero
  always_comb
  begin
    rdata_d = `EIP_BYTE_RESET;
    if (bank == `EIP_BANK_RISE_EN)
      rdata_d = rise_en_q[idx];
    else if (bank == `EIP_BANK_FALL_EN)
      rdata_d = fall_en_q[idx];
    else if (bank == `EIP_BANK_RISE_ST)
      rdata_d = rise_st_q[idx];
    else if (bank == `EIP_BANK_FALL_ST)
      rdata_d = fall_st_q[idx];
    else if (bank == `EIP_BANK_DATA)
      rdata_d = view[idx];
    else if (reg_req.addr == `EIP_ADDR_CTL)
      rdata_d = ctl_q;
  end
  // Read answer one cycle after the request; data holds until the next read
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata  <= `EIP_BYTE_RESET;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= rd;
      if (rd)
        reg_rdata <= rdata_d;
    end
  end
  // Pin drivers; enable low while a port is output and connected
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      line_out  <= '0;
      line_oe_n <= {128{1'b1}};
    end
    else
    begin
      line_out <= drv_q & LIVE_MASK;
      for (int p = 0; p < 16; p++)
        line_oe_n[8*p +: 8] <= ~({8{port_dir_out[p]}} & LIVE_MASK[8*p +: 8]);
    end
  end
  // Interrupt request from any pending bit
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= (|rise_st_q) | (|fall_st_q);
  end

  // Armed rising edge always lands in the rising pending bits
  a_rise_set_armed:
    assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> ((rise_st_q & $past(rise_ev & rise_en_q)) == $past(rise_ev & rise_en_q)))
    else $error("armed rising edge not recorded");
  // A falling pending bit never rises without an armed falling edge
  a_fall_only_armed:
    assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> ((fall_st_q & ~$past(fall_st_q) & ~$past(fall_ev & fall_en_q)) == '0))
    else $error("falling pending set without armed edge");
  // Write one clears in write mode
  a_write_ack_clr:
    assert property (@(posedge clk) disable iff (!resetn)
      (wr && bank == `EIP_BANK_RISE_ST && ack_mode == EIP_ACK_WRITE)
      |=> ((rise_st_q[$past(idx)] & $past(reg_req.wdata) & ~$past(rise_ev[8*idx +: 8])) == 8'h00))
    else $error("write acknowledge did not clear");
  // Read clears in read mode
  a_read_ack_clr:
    assert property (@(posedge clk) disable iff (!resetn)
      (rd && bank == `EIP_BANK_FALL_ST && ack_mode == EIP_ACK_READ)
      |=> ((fall_st_q[$past(idx)] & ~$past(fall_ev[8*idx +: 8] & fall_en_q[idx])) == 8'h00))
    else $error("read acknowledge did not clear");
  // Interrupt follows pending bits one cycle later
  a_irq_any_pend:
    assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> (irq == ($past(|rise_st_q) | $past(|fall_st_q))))
    else $error("interrupt request mismatch");
  // Buffered outputs stand still until commit
  a_hold_buffered:
    assert property (@(posedge clk) disable iff (!resetn)
      (out_en[2] && commit == 3'h0) |=> $stable(drv_q))
    else $error("buffered output moved without commit");
  // Commit of all groups moves every line together
  a_commit_all:
    assert property (@(posedge clk) disable iff (!resetn)
      commit[2] |=> (drv_q == $past(out_q)) ##1 (line_out == ($past(drv_q) & LIVE_MASK)))
    else $error("commit did not update all outputs");
  // Snapshot of every port taken from the readback source on a sample of all groups
  a_snap_sample:
    assert property (@(posedge clk) disable iff (!resetn)
      sample[2] |=> (snap_q == $past(src)))
    else $error("snapshot not taken");
  // Ground variant never drives port 15
  a_gnd_port_idle:
    assert property (@(posedge clk) disable iff (!resetn)
      GND_VARIANT |-> (line_oe_n[127:120] == 8'hff && rise_st_q[15] == 8'h00))
    else $error("ground port active");

endmodule

// File: dv/eip_line_model.sv
// External signal lines on the connectors, with per-line pull-down
`timescale 1ns/10ps
module eip_line_model (
  input  wire logic [127:0] line_out,
  input  wire logic [127:0] line_oe_n,
  input  wire logic [127:0] ext_val,
  input  wire logic [127:0] ext_en,
  output logic      [127:0] line_in
);
  // Device drive wins, then a far source, else the pull-down holds the line low
  always_comb
  begin
    for (int i = 0; i < 128; i++)
    begin
      if (!line_oe_n[i])
        line_in[i] = line_out[i];
      else if (ext_en[i])
        line_in[i] = ext_val[i];
      else
        line_in[i] = 1'b0;  // Released line goes to the pull level
    end
  end
endmodule

// File: dv/test_eip_edge_port.sv
// Self-checking bench for the edge interrupt and port data block
`timescale 1ns/10ps
`include "eip_params.svh"
module test_eip_edge_port;
  import eip_pkg::*;
  logic          clk, resetn, rvalid, irq;
  eip_req_type   req;
  logic [7:0]    rdata, rdata_g, rd_v, rd_g;
  logic [15:0]   dir;
  logic [127:0]  pins, lout, loe_n, lout_g, loe_g, ext_val, ext_en;
  int            errors, comparisons;

  // Two builds share the bus and pins; only the plain one drives the model
  eip_edge_port #(.GND_VARIANT(1'b0)) u_eip_edge_port (.clk(clk), .resetn(resetn),
    .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .port_dir_out(dir),
    .line_in(pins), .line_out(lout), .line_oe_n(loe_n), .irq(irq));
  eip_edge_port #(.GND_VARIANT(1'b1)) u_eip_edge_port_gnd (.clk(clk), .resetn(resetn),
    .reg_req(req), .reg_rdata(rdata_g), .reg_rvalid(), .port_dir_out(dir),
    .line_in(pins), .line_out(lout_g), .line_oe_n(loe_g), .irq());
  eip_line_model u_eip_line_model (.line_out(lout), .line_oe_n(loe_n),
    .ext_val(ext_val), .ext_en(ext_en), .line_in(pins));

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // Write is taken at the posedge between two falling edges
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b1, a, d};
    @(negedge clk);
    req.valid = 1'b0;
  endtask

  // Read answer is looked at in the one cycle that rvalid stands
  task automatic rd(input logic [6:0] a);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    rd_v = rdata;
    rd_g = rdata_g;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    req.valid = 1'b0;
  endtask

  task automatic rc(input string n, input logic [6:0] a, input logic [7:0] e);
    rd(a);
    chk(n, e, rd_v);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic final_report;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    final_report();
  end

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    req = '0;
    dir = 16'h0000;
    ext_val = '0;
    ext_en = '1;
    errors = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    chk("oe_n", 8'hff, loe_n[15:8]);
    chk("out", 8'h00, lout[15:8]);
    rc("rise_arm15", 7'h0f, 8'h00);
    rc("fall_arm3", 7'h13, 8'h00);
    rc("rise_st3", 7'h23, 8'h00);
    rc("fall_st3", 7'h33, 8'h00);
    rc("unmapped", 7'h60, 8'h00);
    wr(7'h03, 8'ha5);
    wr(7'h13, 8'h5a);
    rc("rise_arm3", 7'h03, 8'ha5);
    rc("fall_arm3", 7'h13, 8'h5a);
    ext_val[31:24] = 8'hff;
    settle(8);
    rc("rise_st3", 7'h23, 8'ha5);
    rc("fall_st3", 7'h33, 8'h00);
    chk("irq", 8'h01, {7'h00, irq});
    wr(7'h23, 8'h05);
    rc("rise_st3", 7'h23, 8'ha0);
    wr(7'h23, 8'ha0);
    settle(3);
    chk("irq", 8'h00, {7'h00, irq});
    ext_val[31:24] = 8'h00;
    settle(8);
    rc("fall_st3", 7'h33, 8'h5a);
    wr(`EIP_ADDR_CTL, 8'h40);
    rc("fall_st3", 7'h33, 8'h5a);
    rc("fall_st3", 7'h33, 8'h00);
    settle(3);
    chk("irq", 8'h00, {7'h00, irq});
    // Port 15 edges reach only the plain build
    wr(7'h0f, 8'hff);
    ext_val[127:120] = 8'hff;
    settle(8);
    rd(7'h2f);
    chk("rise_st15", 8'hff, rd_v);
    chk("rise_st15_gnd", 8'h00, rd_g);
    ext_val[23:16] = 8'h3c;
    settle(4);
    rc("port2_in", 7'h42, 8'h3c);
    dir = 16'h0003;
    wr(7'h41, 8'h96);
    settle(2);
    chk("out1", 8'h96, lout[15:8]);
    chk("oe1", 8'h00, loe_n[15:8]);
    rc("port1_rb", 7'h41, 8'h96);
    // Snapshot of the front group, then of all ports
    wr(`EIP_ADDR_CTL, 8'h45);
    ext_val[23:16] = 8'h11;
    settle(4);
    wr(`EIP_ADDR_SIMIO, 8'h01);
    ext_val[23:16] = 8'h22;
    settle(4);
    rc("port2_snap", 7'h42, 8'h11);
    wr(`EIP_ADDR_SIMIO, 8'h04);
    rc("port2_snap", 7'h42, 8'h22);
    rc("port1_snap", 7'h41, 8'h96);
    // Buffered outputs commit by front group, then all together
    wr(`EIP_ADDR_CTL, 8'h68);
    wr(7'h40, 8'h12);
    wr(7'h41, 8'h44);
    settle(3);
    chk("out0_held", 8'h00, lout[7:0]);
    chk("out1_held", 8'h96, lout[15:8]);
    rc("port1_rb", 7'h41, 8'h96);
    wr(`EIP_ADDR_SIMIO, 8'h10);
    @(posedge clk);
    #1;
    chk("out0_com", 8'h12, lout[7:0]);
    chk("out1_com", 8'h44, lout[15:8]);
    wr(7'h41, 8'h77);
    settle(2);
    chk("out1_held2", 8'h44, lout[15:8]);
    wr(`EIP_ADDR_SIMIO, 8'h40);
    @(posedge clk);
    #1;
    chk("out1_all", 8'h77, lout[15:8]);
    chk("out0_all", 8'h12, lout[7:0]);
    // Ground build never drives port 15
    wr(`EIP_ADDR_CTL, 8'h40);
    dir = 16'h8003;
    wr(7'h4f, 8'hff);
    settle(3);
    chk("oe15", 8'h00, loe_n[127:120]);
    chk("out15", 8'hff, lout[127:120]);
    chk("oe15_gnd", 8'hff, loe_g[127:120]);
    chk("out15_gnd", 8'h00, lout_g[127:120]);
    final_report();
  end
endmodule
